// [design/hbi_host_port.sv]
// Host bus interface: bus mode sensing, configuration and cycle decode
// Function
// - Multiplexed bus latches address on strobe rise
// - Remember address strobe low before configuration
// - Then capture address, selects at strobe rise
// - Accept either strobe pair without setting
// - Direction sampled at data strobe fall only
// - Overlap locks device out until reset
// - Word mode still allows byte transfers
// - Byte mode uses low eight lines only
// - Non-multiplexed byte mode option: upper lines give address
// - Acknowledge all cycles, wait only interrupt acknowledge
// - Channel select at configuration picks handshake
// - Acknowledge held low during directed cycle
// - Wait low combinationally until ready
// - Handshake output always actively driven
// - First selected write loads configuration register
// - Wait mode never asserts on register accesses
// - Data/control high reaches FIFO, low registers
// - Configuration register unreachable once written
`timescale 1ns/1ps
module hbi_host_port
  import hbi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bus strobes and selects
  input wire logic addr_latch_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic read_write,
  input wire logic chip_sel_n,
  input wire logic chan_sel_a,
  input wire logic data_ctrl_sel,
  input wire logic byte_xfer_n,
  input wire logic pulsed_int_ack_n,
  input wire logic status_int_ack_n,
  input wire logic rx_dma_ack_a_n,
  input wire logic rx_dma_ack_b_n,
  input wire logic tx_dma_ack_a_n,
  input wire logic tx_dma_ack_b_n,
  // Address/data lines and handshake
  input wire logic [15:0] addr_data_lines_in,
  output logic [15:0] addr_data_lines_out,
  output logic [15:0] addr_data_lines_oe,
  output logic transfer_ack_n,
  // Core side inputs
  input wire logic [3:0] dma_ack_used,
  input wire logic int_ack_ready,
  input wire logic [REG_ADDR_W-1:0] indirect_addr,
  input wire logic [15:0] rd_data,
  // Core side outputs
  output logic [15:0] bus_config,
  output logic cfg_done,
  output logic mux_mode,
  output logic locked_out,
  output logic acc_chan_a,
  output logic [REG_ADDR_W-1:0] acc_addr,
  output logic acc_byte,
  output logic [15:0] wr_data,
  output logic reg_rd_pulse,
  output logic reg_wr_pulse,
  output logic fifo_rd_pulse,
  output logic fifo_wr_pulse
);
  // Counts active strobe or acknowledge inputs
  function automatic logic [3:0] hbi_count_active(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  hbi_pin_if pin ();
  logic [PIN_W-1:0] pins_raw;
  assign pins_raw = {addr_data_lines_in, tx_dma_ack_b_n, tx_dma_ack_a_n, rx_dma_ack_b_n,
    rx_dma_ack_a_n, status_int_ack_n, pulsed_int_ack_n, byte_xfer_n, data_ctrl_sel,
    chan_sel_a, chip_sel_n, read_write, write_strobe_n, read_strobe_n, data_strobe_n,
    addr_latch_strobe_n};
  hbi_pin_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pins_raw(pins_raw),
    .pin_o(pin)
  );

  logic [15:0] ad;
  logic as_low, strobe_on, iack, start_any, overlap;
  logic [7:0] act_vec;
  assign ad = pin.lvl[P_AD +: 16];
  assign as_low = ~pin.lvl[P_AS];
  assign strobe_on = ~pin.lvl[P_DS] | ~pin.lvl[P_RD] | ~pin.lvl[P_WR];
  assign iack = ~pin.lvl[P_PIT] | ~pin.lvl[P_SIT];
  assign start_any = pin.fall[P_DS] | pin.fall[P_RD] | pin.fall[P_WR];
  assign act_vec = {~pin.lvl[P_DS], ~pin.lvl[P_RD], ~pin.lvl[P_WR], ~pin.lvl[P_PIT],
    ~pin.lvl[P_RXA] & dma_ack_used[0], ~pin.lvl[P_RXB] & dma_ack_used[1],
    ~pin.lvl[P_TXA] & dma_ack_used[2], ~pin.lvl[P_TXB] & dma_ack_used[3]};
  assign overlap = hbi_count_active(act_vec) >= 4'h2;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic cfg_done_reg, cfg_done_next, as_seen_reg, as_seen_next;
  logic mux_reg, mux_next, ack_mode_reg, ack_mode_next, lock_reg, lock_next;
  logic [15:0] bus_config_reg, bus_config_next;
  logic [REG_ADDR_W-1:0] lat_addr_reg, lat_addr_next;
  logic lat_chan_reg, lat_chan_next, lat_dc_reg, lat_dc_next, lat_cs_reg, lat_cs_next;
  logic cyc_act_reg, cyc_act_next, cyc_read_reg, cyc_read_next;
  logic cyc_chan_reg, cyc_chan_next, cyc_dc_reg, cyc_dc_next, cyc_byte_reg, cyc_byte_next;
  logic [REG_ADDR_W-1:0] cyc_addr_reg, cyc_addr_next;
  logic [15:0] wdata_reg, wdata_next, ad_out_reg, ad_out_next, ad_oe_reg, ad_oe_next;
  logic [3:0] pulse_reg, pulse_next;
  logic mux_now, sel_cs, sel_chan, sel_dc, byte_only, upper_addr, cyc_end, start_ok;
  logic [REG_ADDR_W-1:0] sel_addr;

  // Selects come from the strobe-latched copy on a multiplexed bus
  always_comb begin
    byte_only = bus_config_reg[BCR_BYTE_ONLY_BIT];
    upper_addr = bus_config_reg[BCR_UPPER_ADDR_BIT];
    mux_now = cfg_done_reg ? mux_reg : (as_seen_reg | as_low);
    sel_cs = mux_now ? lat_cs_reg : ~pin.lvl[P_CS];
    sel_chan = mux_now ? lat_chan_reg : pin.lvl[P_CHAN];
    sel_dc = mux_now ? lat_dc_reg : pin.lvl[P_DC];
    if (mux_now) begin
      sel_addr = lat_addr_reg;
    end else if (byte_only && upper_addr) begin
      sel_addr = ad[15:8];
    end else begin
      sel_addr = indirect_addr;
    end
    start_ok = start_any & sel_cs & ~iack & ~lock_reg & ~cyc_act_reg;
    cyc_end = cyc_act_reg & ~strobe_on;
  end

  // ----------------------------------------
  // Bus mode sensing, lockout and address latch
  // ----------------------------------------
  always_comb begin
    as_seen_next = as_seen_reg | (~cfg_done_reg & as_low);
    lock_next = lock_reg | overlap;
    lat_addr_next = lat_addr_reg;
    lat_chan_next = lat_chan_reg;
    lat_dc_next = lat_dc_reg;
    lat_cs_next = lat_cs_reg;
    if (pin.rise[P_AS]) begin
      lat_addr_next = ad[REG_ADDR_W-1:0];
      lat_chan_next = pin.lvl[P_CHAN];
      lat_dc_next = pin.lvl[P_DC];
      lat_cs_next = ~pin.lvl[P_CS];
    end
  end

  // ----------------------------------------
  // Cycle tracking, configuration write and access pulses
  // ----------------------------------------
  always_comb begin
    cfg_done_next = cfg_done_reg;
    mux_next = mux_reg;
    ack_mode_next = ack_mode_reg;
    bus_config_next = bus_config_reg;
    cyc_act_next = cyc_act_reg;
    cyc_read_next = cyc_read_reg;
    cyc_chan_next = cyc_chan_reg;
    cyc_dc_next = cyc_dc_reg;
    cyc_byte_next = cyc_byte_reg;
    cyc_addr_next = cyc_addr_reg;
    wdata_next = wdata_reg;
    pulse_next = 4'h0;
    ad_out_next = ad_out_reg;
    ad_oe_next = OE_NONE;
    if (start_ok) begin
      cyc_act_next = 1'b1;
      cyc_read_next = pin.fall[P_DS] ? pin.lvl[P_RW] : pin.fall[P_RD];
      cyc_chan_next = sel_chan;
      cyc_dc_next = sel_dc;
      cyc_addr_next = sel_addr;
      cyc_byte_next = byte_only | ~pin.lvl[P_BYTE];
      if (cfg_done_reg && (pin.fall[P_DS] ? pin.lvl[P_RW] : pin.fall[P_RD])) begin
        pulse_next = sel_dc ? 4'h2 : 4'h1;
      end
    end else if (cyc_end) begin
      cyc_act_next = 1'b0;
      if (!cyc_read_reg) begin
        if (!cfg_done_reg) begin
          bus_config_next = wdata_reg;
          cfg_done_next = 1'b1;
          mux_next = as_seen_reg | as_low;
          ack_mode_next = ~cyc_chan_reg;
        end else begin
          pulse_next = cyc_dc_reg ? 4'h8 : 4'h4;
        end
      end
    end
    // Write data tracks the lines while the strobe is low; the synced strobe
    // rise arrives together with lines the host may already have released
    if (cyc_act_reg && !cyc_read_reg && strobe_on) begin
      wdata_next = cyc_byte_reg ? {8'h00, ad[7:0]} : ad;
    end
    if (cyc_act_reg && cyc_read_reg && strobe_on) begin
      ad_out_next = rd_data;
      ad_oe_next = cyc_byte_reg ? OE_BYTE : OE_WORD;
    end
    if (lock_reg) begin
      cyc_act_next = 1'b0;
      pulse_next = 4'h0;
      ad_oe_next = OE_NONE;
    end
  end

  // Registers of all state groups
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      as_seen_reg <= 1'b0;
      lock_reg <= 1'b0;
      lat_addr_reg <= '0;
      lat_chan_reg <= 1'b0;
      lat_dc_reg <= 1'b0;
      lat_cs_reg <= 1'b0;
      cfg_done_reg <= 1'b0;
      mux_reg <= 1'b0;
      ack_mode_reg <= 1'b1;
      bus_config_reg <= BCR_RESET;
      cyc_act_reg <= 1'b0;
      cyc_read_reg <= 1'b0;
      cyc_chan_reg <= 1'b0;
      cyc_dc_reg <= 1'b0;
      cyc_byte_reg <= 1'b0;
      cyc_addr_reg <= '0;
      wdata_reg <= 16'h0000;
      pulse_reg <= 4'h0;
      ad_out_reg <= 16'h0000;
      ad_oe_reg <= OE_NONE;
    end else begin
      as_seen_reg <= as_seen_next;
      lock_reg <= lock_next;
      lat_addr_reg <= lat_addr_next;
      lat_chan_reg <= lat_chan_next;
      lat_dc_reg <= lat_dc_next;
      lat_cs_reg <= lat_cs_next;
      cfg_done_reg <= cfg_done_next;
      mux_reg <= mux_next;
      ack_mode_reg <= ack_mode_next;
      bus_config_reg <= bus_config_next;
      cyc_act_reg <= cyc_act_next;
      cyc_read_reg <= cyc_read_next;
      cyc_chan_reg <= cyc_chan_next;
      cyc_dc_reg <= cyc_dc_next;
      cyc_byte_reg <= cyc_byte_next;
      cyc_addr_reg <= cyc_addr_next;
      wdata_reg <= wdata_next;
      pulse_reg <= pulse_next;
      ad_out_reg <= ad_out_next;
      ad_oe_reg <= ad_oe_next;
    end
  end

  // ----------------------------------------
  // Outputs and handshake
  // ----------------------------------------
  // Full-time driven handshake; wait mode only stalls interrupt acknowledge
  always_comb begin
    if (lock_reg) begin
      transfer_ack_n = 1'b1;
    end else if (ack_mode_reg) begin
      transfer_ack_n = ~(cyc_act_reg | (iack & int_ack_ready));
    end else begin
      transfer_ack_n = ~(iack & ~int_ack_ready);
    end
  end

  assign addr_data_lines_out = ad_out_reg;
  assign addr_data_lines_oe = ad_oe_reg;
  assign bus_config = bus_config_reg;
  assign cfg_done = cfg_done_reg;
  assign mux_mode = mux_reg;
  assign locked_out = lock_reg;
  assign acc_chan_a = cyc_chan_reg;
  assign acc_addr = cyc_addr_reg;
  assign acc_byte = cyc_byte_reg;
  assign wr_data = wdata_reg;
  assign reg_rd_pulse = pulse_reg[0];
  assign fifo_rd_pulse = pulse_reg[1];
  assign reg_wr_pulse = pulse_reg[2];
  assign fifo_wr_pulse = pulse_reg[3];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_cfg_write;
    !cfg_done_reg && cyc_end && !cyc_read_reg;
  endsequence
  sequence s_cfg_loaded;
    cfg_done_reg && bus_config_reg == $past(wdata_reg);
  endsequence

  property p_cfg_first_write;
    s_cfg_write |=> s_cfg_loaded;
  endproperty
  a_cfg_first_write: assert property (p_cfg_first_write) else $error("config not loaded");
  property p_cfg_frozen;
    cfg_done_reg |=> $stable(bus_config_reg) && cfg_done_reg;
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed");
  property p_ack_select;
    s_cfg_write |=> ack_mode_reg == !$past(cyc_chan_reg);
  endproperty
  a_ack_select: assert property (p_ack_select) else $error("bad handshake mode");
  property p_lock;
    hbi_count_active(act_vec) >= 4'h2 |=> lock_reg [*4];
  endproperty
  a_lock: assert property (p_lock) else $error("overlap not locked");
  property p_as_seen;
    !cfg_done_reg && as_low |=> as_seen_reg;
  endproperty
  a_as_seen: assert property (p_as_seen) else $error("strobe low missed");
  property p_dir_sample;
    start_ok && pin.fall[P_DS] |=> cyc_read_reg == $past(pin.lvl[P_RW]);
  endproperty
  a_dir_sample: assert property (p_dir_sample) else $error("direction misread");
  property p_wait_quiet;
    !ack_mode_reg && !iack |-> transfer_ack_n;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) else $error("wait on register cycle");
  property p_ack_hold;
    ack_mode_reg && !lock_reg && cyc_act_reg |-> !transfer_ack_n;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped");
  property p_fifo_route;
    cfg_done_reg && cyc_end && !cyc_read_reg && !lock_reg |=> fifo_wr_pulse == $past(cyc_dc_reg)
      && reg_wr_pulse == !$past(cyc_dc_reg);
  endproperty
  a_fifo_route: assert property (p_fifo_route) else $error("bad write route");
  property p_byte_lanes;
    cyc_byte_reg && |ad_oe_reg |-> ad_oe_reg == OE_BYTE;
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("upper byte driven");
endmodule

// [design/hbi_pin_if.sv]
// Synchronised pin levels and edge pulses between sync and core
`timescale 1ns/1ps
interface hbi_pin_if;
  import hbi_pkg::*;
  logic [PIN_W-1:0] lvl;
  logic [PIN_W-1:0] rise;
  logic [PIN_W-1:0] fall;
  modport src(output lvl, rise, fall);
  modport dst(input lvl, rise, fall);
endinterface

// [design/hbi_pin_sync.sv]
// Two-flop synchroniser with edge detection for all bus pins
`timescale 1ns/1ps
module hbi_pin_sync
  import hbi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw pins and synchronised view
  input wire logic [PIN_W-1:0] pins_raw,
  hbi_pin_if.src pin_o
);
  logic [PIN_W-1:0] s1_reg, s1_next;
  logic [PIN_W-1:0] s2_reg, s2_next;
  logic [PIN_W-1:0] s3_reg, s3_next;

  // ----------------------------------------
  // Synchroniser chain
  // ----------------------------------------
  // Next values of the chain; s1 is read only by s2
  always_comb begin
    s1_next = pins_raw;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  // Chain registers, idle high after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  // ----------------------------------------
  // Edge detection per pin
  // ----------------------------------------
  assign pin_o.lvl = s2_reg;
  for (genvar i = 0; i < PIN_W; i++) begin : g_edge
    assign pin_o.rise[i] = s2_reg[i] & ~s3_reg[i];
    assign pin_o.fall[i] = ~s2_reg[i] & s3_reg[i];
  end
endmodule

// [design/hbi_pkg.sv]
// Shared constants for the host bus interface block
package hbi_pkg;
  // ----------------------------------------
  // Synchronised pin vector layout
  // ----------------------------------------
  localparam int PIN_W = 31;
  localparam int P_AS = 0;
  localparam int P_DS = 1;
  localparam int P_RD = 2;
  localparam int P_WR = 3;
  localparam int P_RW = 4;
  localparam int P_CS = 5;
  localparam int P_CHAN = 6;
  localparam int P_DC = 7;
  localparam int P_BYTE = 8;
  localparam int P_PIT = 9;
  localparam int P_SIT = 10;
  localparam int P_RXA = 11;
  localparam int P_RXB = 12;
  localparam int P_TXA = 13;
  localparam int P_TXB = 14;
  localparam int P_AD = 15;
  localparam logic [PIN_W-1:0] PIN_IDLE = {PIN_W{1'b1}};

  // ----------------------------------------
  // Bus configuration register layout
  // ----------------------------------------
  localparam int BCR_BYTE_ONLY_BIT = 0;
  localparam int BCR_UPPER_ADDR_BIT = 1;
  localparam logic [15:0] BCR_RESET = 16'h0000;
  localparam int REG_ADDR_W = 8;
  localparam logic [15:0] OE_BYTE = 16'h00FF;
  localparam logic [15:0] OE_WORD = 16'hFFFF;
  localparam logic [15:0] OE_NONE = 16'h0000;
endpackage

// [sim/hbi_host_model.sv]
// Host bus master model that drives the device's bus pins
`timescale 1ns/1ps
module hbi_host_model (
  // Clock
  input wire logic clk,
  // Device answers
  input wire logic [15:0] addr_data_lines_out,
  input wire logic [15:0] addr_data_lines_oe,
  input wire logic transfer_ack_n,
  // Bus pins
  output logic addr_latch_strobe_n,
  output logic data_strobe_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic read_write,
  output logic chip_sel_n,
  output logic chan_sel_a,
  output logic data_ctrl_sel,
  output logic byte_xfer_n,
  output logic pulsed_int_ack_n,
  output logic status_int_ack_n,
  output logic rx_dma_ack_a_n,
  output logic [15:0] host_ad
);
  // Idle levels; the strobe pair not in use stays high
  initial begin
    {addr_latch_strobe_n, data_strobe_n, read_strobe_n, write_strobe_n} = 4'hF;
    {pulsed_int_ack_n, status_int_ack_n, rx_dma_ack_a_n, chip_sel_n} = 4'hF;
    {read_write, chan_sel_a, data_ctrl_sel, byte_xfer_n} = 4'h9;
    host_ad = 16'h0000;
  end

  // Multiplexed address phase, ended by the strobe rise
  task automatic addr_phase(input logic [15:0] a, input logic ch);
    @(negedge clk);
    host_ad = a;
    chan_sel_a = ch;
    data_ctrl_sel = 1'b0;
    chip_sel_n = 1'b0;
    addr_latch_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    addr_latch_strobe_n = 1'b1;
    repeat (4) @(negedge clk);
    host_ad = ~a;
  endtask

  // One data cycle; only one strobe low at a time, ack sampled once just before the strobes rise
  task automatic xfer(input logic rd, input logic ds, input logic ch, input logic dc,
                      input logic bn, input logic [15:0] d, output logic ack_end,
                      output logic [15:0] rv, output logic [15:0] ov);
    @(negedge clk);
    chip_sel_n = 1'b0;
    chan_sel_a = ch;
    data_ctrl_sel = dc;
    byte_xfer_n = bn;
    host_ad = rd ? ~host_ad : d;
    read_write = rd;
    if (ds) data_strobe_n = 1'b0;
    else if (rd) read_strobe_n = 1'b0;
    else write_strobe_n = 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      if (i == 2) read_write = ~rd;
    end
    ack_end = transfer_ack_n;
    rv = addr_data_lines_out;
    ov = addr_data_lines_oe;
    {data_strobe_n, read_strobe_n, write_strobe_n, chip_sel_n} = 4'hF;
    host_ad = ~host_ad;
    repeat (8) @(negedge clk);
  endtask

  // Pulsed interrupt acknowledge, recording the handshake at each falling edge
  task automatic int_ack(output logic [11:0] hist);
    @(negedge clk);
    pulsed_int_ack_n = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      hist[i] = transfer_ack_n;
    end
    pulsed_int_ack_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // Deliberate fault: data strobe together with a DMA acknowledge
  task automatic overlap();
    @(negedge clk);
    {chip_sel_n, data_strobe_n, rx_dma_ack_a_n} = 3'h0;
    repeat (4) @(negedge clk);
    {chip_sel_n, data_strobe_n, rx_dma_ack_a_n} = 3'h7;
    repeat (8) @(negedge clk);
  endtask
endmodule

// [sim/host_bus_interface_config_tb.sv]
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module host_bus_interface_config_tb;
  import hbi_pkg::*;
  typedef struct {logic rd, ds, ch, dc, bn; logic [15:0] d, wd, out, oe; logic [3:0] p;} hbi_row_t;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic as_n, ds_n, rd_n, wr_n, rw, cs_n, ch_a, dc_sel, byte_n, pit_n, sit_n, rxa_n;
  logic [15:0] host_ad, ad_in, ad_out, ad_oe, rd_data, bus_config, wr_data, cap_wd, rv, ov;
  logic [3:0] dma_ack_used = 4'h0;
  logic [3:0] seen;
  logic [7:0] indirect_addr = 8'h21;
  logic [7:0] acc_addr;
  logic [11:0] hist;
  logic int_ack_ready = 1'b0;
  logic ack_n, cfg_done, mux_mode, locked_out, acc_chan_a, acc_byte, ack_end;
  logic reg_rd_pulse, reg_wr_pulse, fifo_rd_pulse, fifo_wr_pulse;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  hbi_row_t rows [6] = '{
    '{0, 0, 1, 0, 1, 16'hA55A, 16'hA55A, 16'h0000, 16'h0000, 4'h2},
    '{0, 1, 0, 1, 1, 16'h1234, 16'h1234, 16'h0000, 16'h0000, 4'h8},
    '{1, 0, 1, 0, 1, 16'hC3C3, 16'h0000, 16'hC3C3, 16'hFFFF, 4'h1},
    '{1, 1, 0, 1, 1, 16'h5AA5, 16'h0000, 16'h5AA5, 16'hFFFF, 4'h4},
    '{0, 0, 1, 1, 0, 16'hBEEF, 16'h00EF, 16'h0000, 16'h0000, 4'h8},
    '{1, 0, 0, 0, 0, 16'h7E81, 16'h0000, 16'h0081, 16'h00FF, 4'h1}};

  // Clock, wire level of the shared lines
  always #10 clk = ~clk;
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & host_ad);

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  hbi_host_model u_host (.clk(clk), .addr_data_lines_out(ad_out), .addr_data_lines_oe(ad_oe),
    .transfer_ack_n(ack_n), .addr_latch_strobe_n(as_n), .data_strobe_n(ds_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .read_write(rw), .chip_sel_n(cs_n),
    .chan_sel_a(ch_a), .data_ctrl_sel(dc_sel), .byte_xfer_n(byte_n), .pulsed_int_ack_n(pit_n),
    .status_int_ack_n(sit_n), .rx_dma_ack_a_n(rxa_n), .host_ad(host_ad));
  hbi_host_port DUT (.clk(clk), .arst_n(arst_n), .addr_latch_strobe_n(as_n),
    .data_strobe_n(ds_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .read_write(rw),
    .chip_sel_n(cs_n), .chan_sel_a(ch_a), .data_ctrl_sel(dc_sel), .byte_xfer_n(byte_n),
    .pulsed_int_ack_n(pit_n), .status_int_ack_n(sit_n), .rx_dma_ack_a_n(rxa_n),
    .rx_dma_ack_b_n(1'b1), .tx_dma_ack_a_n(1'b1), .tx_dma_ack_b_n(1'b1),
    .addr_data_lines_in(ad_in), .addr_data_lines_out(ad_out), .addr_data_lines_oe(ad_oe),
    .transfer_ack_n(ack_n), .dma_ack_used(dma_ack_used), .int_ack_ready(int_ack_ready),
    .indirect_addr(indirect_addr), .rd_data(rd_data), .bus_config(bus_config),
    .cfg_done(cfg_done), .mux_mode(mux_mode), .locked_out(locked_out), .acc_chan_a(acc_chan_a),
    .acc_addr(acc_addr), .acc_byte(acc_byte), .wr_data(wr_data), .reg_rd_pulse(reg_rd_pulse),
    .reg_wr_pulse(reg_wr_pulse), .fifo_rd_pulse(fifo_rd_pulse), .fifo_wr_pulse(fifo_wr_pulse));

  // ----------------------------------------
  // Monitors and helpers
  // ----------------------------------------
  // Collect pulses and write data; watch the handshake is always driven
  always @(posedge clk) begin
    seen <= seen | {fifo_wr_pulse, fifo_rd_pulse, reg_wr_pulse, reg_rd_pulse};
    if (reg_wr_pulse === 1'b1 || fifo_wr_pulse === 1'b1) cap_wd <= wr_data;
    if (arst_n && ack_n !== 1'b0 && ack_n !== 1'b1) begin
      n_errors++;
      $display("MISMATCH transfer_ack_n expected 0 or 1 seen %b", ack_n);
    end
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // Compare one value and count it
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Reset held for five cycles
  task automatic do_reset();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // Write cycle with a fresh pulse record
  task automatic wr(input logic ch, input logic [15:0] d);
    seen = 4'h0;
    u_host.xfer(1'b0, 1'b0, ch, 1'b0, 1'b1, d, ack_end, rv, ov);
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seen = 4'h0;
    cap_wd = 16'h0000;
    rd_data = 16'h0000;
    do_reset();
    chk("oe_after_reset", OE_NONE, ad_oe);
    chk("config_after_reset", BCR_RESET, bus_config);
    wr(1'b0, 16'h8000);
    chk("config_loaded", 16'h8000, bus_config);
    chk("config_flags", 16'h0020, {10'h000, cfg_done, mux_mode, seen});
    foreach (rows[i]) begin
      seen = 4'h0;
      rd_data = rows[i].d;
      u_host.xfer(rows[i].rd, rows[i].ds, rows[i].ch, rows[i].dc, rows[i].bn, rows[i].d,
                  ack_end, rv, ov);
      chk("pulses", {12'h000, rows[i].p}, {12'h000, seen});
      chk("ack_held", 16'h0000, {15'h0000, ack_end});
      chk("oe", rows[i].oe, ov);
      chk("read_data", rows[i].out, rv & ov);
      if (!rows[i].rd) chk("write_data", rows[i].wd, cap_wd);
      chk("access", {6'h00, rows[i].ch, ~rows[i].bn, indirect_addr},
          {6'h00, acc_chan_a, acc_byte, acc_addr});
    end
    wr(1'b1, 16'h0003);
    chk("config_kept", 16'h8000, bus_config);
    chk("rewrite_pulse", 16'h0002, {12'h000, seen});
    dma_ack_used = 4'h1;
    u_host.overlap();
    wr(1'b1, 16'h1111);
    chk("lockout", 16'h0021, {10'h000, locked_out, seen, ack_end});
    do_reset();
    chk("lock_cleared", 16'h0000, {15'h0000, locked_out});
    u_host.addr_phase(16'h005A, 1'b1);
    wr(1'b1, 16'h0001);
    chk("mux_config", 16'h0003, {14'h0000, mux_mode, bus_config[0]});
    u_host.addr_phase(16'h0033, 1'b1);
    wr(1'b1, 16'hABCD);
    chk("mux_addr", 16'h0033, {8'h00, acc_addr});
    chk("byte_write", 16'h00CD, cap_wd);
    chk("wait_quiet", 16'h0001, {15'h0000, ack_end});
    fork
      u_host.int_ack(hist);
      begin
        repeat (7) @(negedge clk);
        int_ack_ready = 1'b1;
      end
    join
    chk("wait_steps", 16'h0002, {14'h0000, hist[11], hist[4]});
    int_ack_ready = 1'b0;
    do_reset();
    wr(1'b0, 16'h0003);
    wr(1'b0, 16'h3C77);
    chk("upper_addr", 16'h3C77, {acc_addr, cap_wd[7:0]});
    tally_and_finish();
  end
endmodule
